// ===== tb/rcs_engine_model.sv
// Behavioural search engine that answers each grant after a set lag.
module rcs_engine_model
(
    // Clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // Grant from the store
    input wire logic engStart,
    input wire logic engAbort,
    input wire logic [10:0] engRecAddr,
    input wire logic [15:0] engCtx,
    input wire logic [9:0] lag,
    // Results
    output logic engDone,
    output logic [15:0] engRecNum,
    output logic [15:0] engNextCtx,
    output logic engImgWe,
    output logic [10:0] engImgIdx,
    output logic [15:0] engImgData
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [9:0] cnt;
    logic run;
    logic [15:0] ctx;

    // Result lines toggle outside the done pulse so stale data never matches.
    always @(posedge mclk or negedge resetn)
        if (!resetn)
        begin
            run <= 1'b0;
            engDone <= 1'b0;
            engImgWe <= 1'b0;
            engRecNum <= 16'h0000;
            engNextCtx <= 16'h0000;
            engImgData <= 16'h0000;
        end
        else
        begin
            engDone <= 1'b0;
            engImgWe <= 1'b0;
            engRecNum <= ~engRecNum;
            engNextCtx <= ~engNextCtx;
            engImgData <= ~engImgData;
            cnt <= cnt - 10'h001;
            if (engStart)
            begin
                run <= 1'b1;
                cnt <= lag;
                ctx <= engCtx;
                engImgIdx <= engRecAddr + 11'h001;
            end
            else if (engAbort)
                run <= 1'b0;
            else if (run && cnt == 10'h001)
            begin
                engImgWe <= 1'b1;
                engImgData <= ctx ^ 16'h5a5a;
            end
            else if (run && cnt == 10'h000)
            begin
                run <= 1'b0;
                engDone <= 1'b1;
                engRecNum <= ctx + 16'h0001;
                engNextCtx <= ctx + 16'h0001;
            end
        end
endmodule // rcs_engine_model

// ===== tb/rcs_record_store_sva.sv
// Port-level assertions for the record store.
module rcs_record_store_sva
(
    // Clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // Register ports
    input wire logic [10:0] rackAddr,
    input wire logic rackWe,
    input wire logic [15:0] rackWrData,
    input wire logic [15:0] rackRdData,
    input wire logic rackIsInput,
    input wire logic [13:0] fpAddr,
    input wire logic fpWe,
    input wire logic [15:0] fpRdData,
    // Engine and indicators
    input wire logic engStart,
    input wire logic engAbort,
    input wire logic engBusy,
    input wire logic searchingLed,
    input wire logic initDone
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!resetn);

    a_start_pulse: assert property (
        engStart |=> !engStart) else $error("start pulse too long");
    a_start_busy: assert property (
        engStart |-> ##[0:1] engBusy) else $error("grant without busy");
    a_abort_busy: assert property (
        engAbort |-> $past(engBusy)) else $error("abort while idle");
    a_rebuild_idle: assert property (
        searchingLed |-> !engStart) else $error("grant during rebuild");
    a_rack_store: assert property (
        (rackWe && initDone && !rackIsInput && $stable(rackAddr) && !fpWe
        && !engBusy && !searchingLed) ##1 $stable(rackAddr)[*2]
        |-> rackRdData == $past(rackWrData, 2))
        else $error("rack write lost");
    a_fp_lockreg: assert property (
        fpAddr == 14'h2000 ##1 $stable(fpAddr) |-> fpRdData[15:2] == 14'h0)
        else $error("lock register upper bits set");
    a_fp_unmapped: assert property (
        (fpAddr == 14'h0000 || (fpAddr > 14'h0800 && fpAddr != 14'h2000))
        ##1 $stable(fpAddr) |-> fpRdData == 16'h0000)
        else $error("unmapped front read not zero");
    a_fp_takeover: assert property (
        (fpWe && initDone && fpAddr == {3'h0, rackAddr} + 14'h0001)
        ##1 $stable(rackAddr)[*2] |-> rackIsInput)
        else $error("front write left output");

    c_grant: cover property (engStart);
    c_abort: cover property (engAbort);
    c_rebuild: cover property ($rose(searchingLed));
endmodule // rcs_record_store_sva

bind rcs_record_store rcs_record_store_sva i_sva (.*);

// ===== tb/rcs_record_store_tb.sv
// Self-checking bench for the record store and its engine partner.
`include "rcs_regs.vh"
module rcs_record_store_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk = 1'b0;
    logic resetn = 1'b0;
    logic [10:0] rackAddr = 11'h000;
    logic rackWe = 1'b0;
    logic [15:0] rackWrData = 16'h0000;
    logic [13:0] fpAddr = 14'h0000;
    logic fpWe = 1'b0;
    logic [15:0] fpWrData = 16'h0000;
    logic [9:0] lag = 10'h004;
    logic [15:0] rackRdData, fpRdData, engCmd, engCtx, engRecNum, engNextCtx;
    logic [15:0] engImgData, d, v;
    logic [10:0] engRecAddr, engImgIdx;
    logic [3:0] engWin;
    logic rackIsInput, engStart, engAbort, engBusy, engDone, engImgWe, inp;
    logic searchingLed, notFoundLed, initDone;
    logic [15:0] winQ[$], recQ[$], ctxQ[$];
    int n_errors = 0;
    int num_checks = 0;
    int seed = 95230;

    rcs_record_store #(.SEARCH_CYC_PER_REC(32'd1)) i_dut (.*);
    rcs_engine_model i_eng (.*);

    always #2.5 mclk = ~mclk;
    always @(posedge mclk)
        if (engStart === 1'b1)
        begin
            winQ.push_back({12'h000, engWin});
            recQ.push_back({5'h00, engRecAddr});
            ctxQ.push_back(engCtx);
        end

    task automatic chk(string name, logic [15:0] seen, logic [15:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("unexpected %s: expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic close_out;
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic tick;
        @(posedge mclk);
        #1;
    endtask
    task automatic rwr(int a, logic [15:0] val);
        rackAddr = a[10:0];
        rackWrData = val;
        rackWe = 1'b1;
        tick;
        rackWe = 1'b0;
        tick;
    endtask
    task automatic fwr(int a, logic [15:0] val);
        fpAddr = a[13:0];
        fpWrData = val;
        fpWe = 1'b1;
        tick;
        fpWe = 1'b0;
        tick;
    endtask
    task automatic rrd(int a);
        rackAddr = a[10:0];
        tick;
        tick;
        d = rackRdData;
        inp = rackIsInput;
    endtask
    task automatic frd(int a);
        fpAddr = a[13:0];
        tick;
        tick;
        d = fpRdData;
    endtask
    task automatic waitm(int a, logic [15:0] m, logic [15:0] val, string name);
        rrd(a);
        for (int k = 0; k < 600 && (d & m) !== val; k++)
            rrd(a);
        chk(name, d & m, val);
    endtask
    // Status index of window w: two files, one-word records, four per window.
    function automatic int sidx(int w);
        return w < 3 ? 6 + 4 * w : 22 + 4 * (w - 3);
    endfunction

    task automatic cfg(logic [15:0] len, logic bad);
        rwr(0, 16'h0002);
        rwr(0, 16'h8002);
        waitm(6, 16'h8000, 16'h8000, "ready");
        rrd(7);
        chk("exempt dir", {15'h0, inp}, 16'h0001);
        rrd(40);
        chk("writable", {15'h0, inp}, 16'h0000);
        rwr(2, len);
        rwr(3, 16'd3);
        rwr(4, 16'd200);
        rwr(5, 16'd1);
        rwr(18, 16'd1);
        rwr(19, 16'd2);
        rwr(20, 16'd100);
        rwr(21, 16'd1);
        for (int w = 0; w < 5; w++)
            rwr(sidx(w) + 3, 16'h0000);
        rwr(0, 16'h0002);
        chk("searching", {15'h0, searchingLed}, 16'h0001);
        waitm(6, 16'h8000, 16'h0000, "ready clear");
        repeat (4) tick;
        chk("searching off", {15'h0, searchingLed}, 16'h0000);
        chk("invalid flag", {15'h0, notFoundLed}, {15'h0, bad});
    endtask

    task automatic op(int w, logic [15:0] cmd, logic [15:0] expSt);
        rwr(sidx(w) + 3, cmd);
        waitm(sidx(w), 16'hffff, expSt, "status");
        rrd(sidx(w) + 1);
        if (expSt === cmd)
            chk("result dir", {15'h0, inp}, 16'h0001);
        if (expSt === cmd)
            chk("record number", d, ctxQ[$] + 16'h0001);
        rwr(sidx(w) + 3, 16'h0000);
        waitm(sidx(w), 16'hffff, 16'h0000, "status clear");
        rrd(sidx(w) + 1);
        chk("record dir", {15'h0, inp}, 16'h0000);
    endtask

    initial
    begin
        repeat (16) tick;
        resetn = 1'b1;
        for (int k = 0; k < 3000 && initDone !== 1'b1; k++)
            tick;
        v = 16'($random(seed));
        rrd(40);
        fwr(41, v);
        rrd(40);
        chk("front dir", {15'h0, inp}, 16'h0001);
        rwr(40, ~v);
        frd(41);
        chk("front map", d, v);
        frd(3000);
        chk("unmapped", d, 16'h0000);
        fwr(8192, 16'hfffe);
        frd(8192);
        chk("lock reg", d, 16'h0002);
        cfg(16'd65, 1'b1);
        cfg(16'd1, 1'b0);
        for (int i = 0; i < 9; i++)
            if ((`RCS_CMD_WPROT_MASK >> i) & 1)
                op(1, 16'h1 << i, (16'h1 << i) | `RCS_ST_REFUSED);
        fwr(8192, 16'h0000);
        for (int i = 0; i < 2; i++)
        begin
            lag = 10'(2 + ($random(seed) & 7));
            op(0, 16'h0001, 16'h0001);
            chk("context", ctxQ[$], i[15:0]);
        end
        lag = 10'd40;
        winQ.delete();
        recQ.delete();
        for (int w = 1; w < 4; w++)
            rwr(sidx(w) + 3, 16'h0010);
        waitm(sidx(2), 16'hffff, 16'h0010, "last done");
        chk("first grant", winQ[0], 16'd1);
        chk("second grant", winQ[1], 16'd3);
        chk("third grant", winQ[2], 16'd2);
        chk("record addr", recQ[1], 16'(sidx(3) + 1));
        for (int w = 1; w < 4; w++)
            rwr(sidx(w) + 3, 16'h0000);
        for (int w = 1; w < 4; w++)
            waitm(sidx(w), 16'hffff, 16'h0000, "released");
        lag = 10'd400;
        op(0, 16'h0008, 16'h0008 | `RCS_ST_TIMEOUT);
        lag = 10'd5;
        fwr(sidx(4) + 4, 16'h0010);
        waitm(sidx(4), 16'hffff, 16'h0010, "front op");
        fwr(sidx(4) + 4, 16'h0000);
        waitm(sidx(4), 16'hffff, 16'h0000, "front clear");
        rrd(sidx(4) + 3);
        chk("command kept", {15'h0, inp}, 16'h0001);
        fwr(8192, 16'h0001);
        rwr(0, 16'h8002);
        repeat (8) tick;
        rrd(6);
        chk("locked ready", d & 16'h8000, 16'h0000);
        rrd(40);
        chk("locked dirs", {15'h0, inp}, 16'h0000);
        rwr(0, 16'h0002);
        fwr(8192, 16'h0000);
        close_out;
    end

    initial
    begin
        #400us;
        n_errors++;
        close_out;
    end
endmodule // rcs_record_store_tb

// ===== verilog/rcs_prio_arb.v
// Fixed-priority window arbiter: first windows first, then by number.
module rcs_prio_arb
#(
    parameter NWIN = 16,
    parameter IW = 4
)
(
    // Requests
    input wire [NWIN-1:0] pending,
    input wire [NWIN-1:0] firstMask,
    // Grant
    output wire grantValid,
    output wire [IW-1:0] grantIdx
);

    function [IW-1:0] lowestIdx;
        input [NWIN-1:0] vec;
        integer k;
        begin
            lowestIdx = {IW{1'b0}};
            for (k = NWIN - 1; k >= 0; k = k - 1)
            begin
                if (vec[k])
                    lowestIdx = k[IW-1:0];
            end
        end
    endfunction

    wire [NWIN-1:0] firstPend;

    assign firstPend = pending & firstMask;
    assign grantValid = |pending;
    assign grantIdx = (|firstPend) ? lowestIdx(firstPend) : lowestIdx(pending);

endmodule // rcs_prio_arb

// ===== verilog/rcs_record_store.v
// Interface registers, configuration sequencer and window arbitration.
`include "rcs_regs.vh"
// Operation
// - First windows, then lower files, win arbitration
// - Searches aborted after max record over rate
// - Config entered by setting file-count bit 16
// - Config entry makes all registers writable except 8
// - Ready bit 16 of register 7 set
// - File definitions decode the register layout
// - Clearing bit rebuilds, erases, lights searching
// - Ready bit cleared when configuration done
// - Invalid configuration lights not-found indicator
// - Front port numbers 1-2048 hit interface
// - Register 8192 reachable from front only
// - Lock bit ignores configuration requests
// - Write-protect bit refuses store and delete
// - Front port reads have no side effects
// - Front port write makes register controller input
// - Record registers taken when the engine reports done, returned when command cleared
// - Other taken registers stay until reconfigure
// - Controller port accesses equal rack accesses
// - Separate sequential context per window
// - One arbitration over all window sources
// - Command cleared returns outputs, clears completion
module rcs_record_store
#(
    parameter MAXW = 16,
    parameter IW = 4,
    parameter MAXREC = 64,
    parameter [31:0] SEARCH_CYC_PER_REC = `RCS_SEARCH_CYC_PER_REC
)
(
    // Clock and reset
    input wire mclk,
    input wire resetn,
    // Rack bus, register index = register number - 1
    input wire [10:0] rackAddr,
    input wire rackWe,
    input wire [15:0] rackWrData,
    output reg [15:0] rackRdData,
    output reg rackIsInput,
    // Front port, register number
    input wire [13:0] fpAddr,
    input wire fpWe,
    input wire [15:0] fpWrData,
    output reg [15:0] fpRdData,
    // Search engine
    output reg engStart,
    output reg [IW-1:0] engWin,
    output reg [15:0] engCmd,
    output reg [10:0] engRecAddr,
    output reg [15:0] engCtx,
    output reg engAbort,
    output wire engBusy,
    input wire engDone,
    input wire [15:0] engRecNum,
    input wire [15:0] engNextCtx,
    input wire engImgWe,
    input wire [10:0] engImgIdx,
    input wire [15:0] engImgData,
    // Indicators
    output reg searchingLed,
    output reg notFoundLed,
    output reg initDone
);

    localparam [2:0] ST_INIT = 3'h0;
    localparam [2:0] ST_RUN = 3'h1;
    localparam [2:0] ST_CFG = 3'h2;
    localparam [2:0] ST_BFILE = 3'h3;
    localparam [2:0] ST_BWIN = 3'h4;
    localparam [2:0] ST_ERASE = 3'h5;

    reg [15:0] mem [0:2047];
    reg [2047:0] dir;
    reg [1:0] frontReg;
    reg [2:0] state;
    reg [10:0] ptr;
    reg [IW:0] numWin;
    reg [10:0] winStat [0:MAXW-1];
    reg [10:0] winRec [0:MAXW-1];
    reg [10:0] winCmd [0:MAXW-1];
    reg [10:0] winLen [0:MAXW-1];
    reg [15:0] winMax [0:MAXW-1];
    reg [15:0] ctx [0:MAXW-1];
    reg [MAXW-1:0] winFirst;
    reg [15:0] fileIdx;
    reg [23:0] defPtr;
    reg [23:0] winBase;
    reg [15:0] winLeft;
    reg [15:0] nwinCur;
    reg [15:0] lenCur;
    reg [15:0] maxCur;
    reg [31:0] slotSum;
    reg bad;
    reg busy;
    reg [IW-1:0] actWin;
    reg [31:0] timer;
    reg [IW-1:0] scanIdx;
    integer i;
    integer j;

    wire [MAXW-1:0] pending;
    wire grantValid;
    wire [IW-1:0] grantIdx;
    wire [15:0] grantCmd;
    wire [15:0] scanCmd;
    wire [15:0] scanStat;
    wire fpMem;
    wire [10:0] fpIdx;
    wire [31:0] slotAdd;
    wire [31:0] searchLimit;

    assign engBusy = busy;
    assign fpMem = (fpAddr != 14'h0000) && (fpAddr <= {2'b00, `RCS_NUM_IFREGS});
    assign fpIdx = fpAddr[10:0] - 11'h001;
    assign grantCmd = mem[winCmd[grantIdx]];
    assign scanCmd = mem[winCmd[scanIdx]];
    assign scanStat = mem[winStat[scanIdx]];
    assign slotAdd = ({16'h0000, mem[defPtr[10:0] + 11'h002]} + 32'h1)
        * ({16'h0000, mem[defPtr[10:0]]} + 32'h1);
    assign searchLimit = {16'h0000, winMax[actWin]} * SEARCH_CYC_PER_REC;

    // ------------------------------------------------------------------
    // Pending windows
    // ------------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < MAXW; g = g + 1)
        begin : gPend
            assign pending[g] = (g < numWin) && (state == ST_RUN)
                && !(busy && (actWin == g))
                && (mem[winCmd[g]] != 16'h0000)
                && (mem[winStat[g]] == 16'h0000);
        end
    endgenerate

    rcs_prio_arb #(.NWIN(MAXW), .IW(IW)) uArb
    (
        .pending(pending),
        .firstMask(winFirst),
        .grantValid(grantValid),
        .grantIdx(grantIdx)
    );

    // ------------------------------------------------------------------
    // Read ports
    // ------------------------------------------------------------------
    always @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            rackRdData <= 16'h0000;
            rackIsInput <= 1'b0;
            fpRdData <= 16'h0000;
        end
        else
        begin
            rackRdData <= mem[rackAddr];
            rackIsInput <= dir[rackAddr];
            if (fpMem)
                fpRdData <= mem[fpIdx];
            else if (fpAddr == `RCS_NUM_FRONT_ONLY)
                fpRdData <= {14'h0000, frontReg};
            else
                fpRdData <= 16'h0000;
        end
    end

    // ------------------------------------------------------------------
    // Register array, no reset: the init state clears it.
    // ------------------------------------------------------------------
    always @(posedge mclk)
    begin
        if (state != ST_INIT && rackWe && !dir[rackAddr])
            mem[rackAddr] <= rackWrData;
        if (state != ST_INIT && fpWe && fpMem)
            mem[fpIdx] <= fpWrData;
        if (engImgWe && busy)
            mem[engImgIdx] <= engImgData;
        case (state)
            ST_INIT:
                mem[ptr] <= 16'h0000;
            ST_RUN:
            begin
                if (mem[`RCS_IDX_FILE_COUNT][`RCS_BIT_CFG]
                    && !frontReg[`RCS_BIT_LOCK] && !busy)
                    mem[`RCS_IDX_READY][`RCS_BIT_CFG] <= 1'b1;
                if (grantValid && !busy && frontReg[`RCS_BIT_WPROT]
                    && (grantCmd & `RCS_CMD_WPROT_MASK) != 16'h0000)
                    mem[winStat[grantIdx]] <= grantCmd | `RCS_ST_REFUSED;
                if (busy && engDone)
                begin
                    mem[winRec[actWin]] <= engRecNum;
                    mem[winStat[actWin]] <= mem[winCmd[actWin]];
                end
                else if (busy && timer >= searchLimit)
                    mem[winStat[actWin]] <= mem[winCmd[actWin]]
                        | `RCS_ST_TIMEOUT;
                if ({1'b0, scanIdx} < numWin && !(busy && actWin == scanIdx)
                    && scanCmd == 16'h0000 && scanStat != 16'h0000)
                    mem[winStat[scanIdx]] <= 16'h0000;
            end
            ST_BWIN:
                if (winLeft != 16'h0000 && winBase[10:0] != `RCS_IDX_READY
                    && winBase < {12'h000, `RCS_NUM_IFREGS})
                    mem[winBase[10:0]] <= 16'h0000;
            ST_ERASE:
                if (ptr == MAXW - 1)
                    mem[`RCS_IDX_READY][`RCS_BIT_CFG] <= 1'b0;
            default:
                ;
        endcase
    end

    // ------------------------------------------------------------------
    // Directions, lock register, sequencer and window service
    // ------------------------------------------------------------------
    always @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            dir <= {2048{1'b0}};
            frontReg <= 2'b00;
            state <= ST_INIT;
            ptr <= 11'h000;
            numWin <= {(IW+1){1'b0}};
            winFirst <= {MAXW{1'b0}};
            for (i = 0; i < MAXW; i = i + 1)
            begin
                winStat[i] <= 11'h000;
                winRec[i] <= 11'h000;
                winCmd[i] <= 11'h000;
                winLen[i] <= 11'h000;
                winMax[i] <= 16'h0000;
                ctx[i] <= 16'h0000;
            end
            fileIdx <= 16'h0000;
            defPtr <= 24'h000000;
            winBase <= 24'h000000;
            winLeft <= 16'h0000;
            nwinCur <= 16'h0000;
            lenCur <= 16'h0000;
            maxCur <= 16'h0000;
            slotSum <= 32'h00000000;
            bad <= 1'b0;
            busy <= 1'b0;
            actWin <= {IW{1'b0}};
            timer <= 32'h00000000;
            scanIdx <= {IW{1'b0}};
            engStart <= 1'b0;
            engWin <= {IW{1'b0}};
            engCmd <= 16'h0000;
            engRecAddr <= 11'h000;
            engCtx <= 16'h0000;
            engAbort <= 1'b0;
            searchingLed <= 1'b0;
            notFoundLed <= 1'b0;
            initDone <= 1'b0;
        end
        else
        begin
            engStart <= 1'b0;
            engAbort <= 1'b0;
            scanIdx <= scanIdx + 1'b1;
            if (fpWe && fpAddr == `RCS_NUM_FRONT_ONLY)
                frontReg <= fpWrData[1:0];
            if (state != ST_INIT && fpWe && fpMem)
                dir[fpIdx] <= 1'b1;
            case (state)
                ST_INIT:
                begin
                    ptr <= ptr + 11'h001;
                    if (ptr == 11'h7ff)
                    begin
                        state <= ST_RUN;
                        initDone <= 1'b1;
                    end
                end
                ST_RUN:
                begin
                    if (mem[`RCS_IDX_FILE_COUNT][`RCS_BIT_CFG]
                        && !frontReg[`RCS_BIT_LOCK] && !busy)
                    begin
                        dir <= {2048{1'b0}};
                        dir[`RCS_IDX_CFG_EXEMPT] <= 1'b1;
                        numWin <= {(IW+1){1'b0}};
                        winFirst <= {MAXW{1'b0}};
                        notFoundLed <= 1'b0;
                        state <= ST_CFG;
                    end
                    else if (grantValid && !busy)
                    begin
                        if (!(frontReg[`RCS_BIT_WPROT] && (grantCmd
                            & `RCS_CMD_WPROT_MASK) != 16'h0000))
                        begin
                            busy <= 1'b1;
                            actWin <= grantIdx;
                            timer <= 32'h00000000;
                            engStart <= 1'b1;
                            engWin <= grantIdx;
                            engCmd <= grantCmd;
                            engRecAddr <= winRec[grantIdx];
                            engCtx <= ctx[grantIdx];
                        end
                    end
                    if (busy)
                    begin
                        timer <= timer + 32'h1;
                        if (engDone)
                        begin
                            busy <= 1'b0;
                            ctx[actWin] <= engNextCtx;
                            dir[winRec[actWin]] <= 1'b1;
                            for (j = 0; j < MAXREC; j = j + 1)
                                if (j < winLen[actWin])
                                    dir[winRec[actWin] + 1 + j] <= 1'b1;
                        end
                        else if (timer >= searchLimit)
                        begin
                            busy <= 1'b0;
                            engAbort <= 1'b1;
                        end
                    end
                    if ({1'b0, scanIdx} < numWin
                        && !(busy && actWin == scanIdx)
                        && scanCmd == 16'h0000 && scanStat != 16'h0000)
                    begin
                        dir[winRec[scanIdx]] <= 1'b0;
                        for (j = 0; j < MAXREC; j = j + 1)
                            if (j < winLen[scanIdx])
                                dir[winRec[scanIdx] + 1 + j] <= 1'b0;
                    end
                end
                ST_CFG:
                    if (!mem[`RCS_IDX_FILE_COUNT][`RCS_BIT_CFG])
                    begin
                        state <= ST_BFILE;
                        searchingLed <= 1'b1;
                        fileIdx <= 16'h0000;
                        defPtr <= {12'h000, `RCS_IDX_FIRST_DEF};
                        slotSum <= 32'h00000000;
                        bad <= (mem[`RCS_IDX_FILE_COUNT][14:0] == 15'h0000);
                    end
                ST_BFILE:
                    if (fileIdx == {1'b0, mem[`RCS_IDX_FILE_COUNT][14:0]}
                        || defPtr + 24'h4 > {12'h000, `RCS_NUM_IFREGS})
                    begin
                        if (defPtr > {12'h000, `RCS_NUM_IFREGS}
                            || fileIdx != {1'b0,
                            mem[`RCS_IDX_FILE_COUNT][14:0]}
                            || slotSum > `RCS_MAX_SLOTS)
                            bad <= 1'b1;
                        state <= ST_ERASE;
                        ptr <= 11'h000;
                    end
                    else
                    begin
                        lenCur <= mem[defPtr[10:0]];
                        nwinCur <= mem[defPtr[10:0] + 11'h001];
                        winLeft <= mem[defPtr[10:0] + 11'h001];
                        maxCur <= mem[defPtr[10:0] + 11'h002];
                        winBase <= defPtr + 24'h4;
                        slotSum <= slotSum + slotAdd;
                        if (mem[defPtr[10:0]] == 16'h0000
                            || mem[defPtr[10:0]] > MAXREC
                            || mem[defPtr[10:0] + 11'h001] == 16'h0000
                            || mem[defPtr[10:0] + 11'h003] == 16'h0000
                            || mem[defPtr[10:0] + 11'h003]
                            > mem[defPtr[10:0]])
                            bad <= 1'b1;
                        state <= ST_BWIN;
                    end
                ST_BWIN:
                    if (winLeft == 16'h0000
                        || winBase > {12'h000, `RCS_NUM_IFREGS})
                    begin
                        defPtr <= winBase;
                        fileIdx <= fileIdx + 16'h0001;
                        state <= ST_BFILE;
                    end
                    else
                    begin
                        if (numWin < MAXW && winBase + {8'h00, lenCur}
                            + 24'h3 <= {12'h000, `RCS_NUM_IFREGS})
                        begin
                            winStat[numWin[IW-1:0]] <= winBase[10:0];
                            winRec[numWin[IW-1:0]] <= winBase[10:0] + 11'h001;
                            winCmd[numWin[IW-1:0]] <= winBase[10:0]
                                + lenCur[10:0] + 11'h002;
                            winLen[numWin[IW-1:0]] <= lenCur[10:0];
                            winMax[numWin[IW-1:0]] <= maxCur;
                            winFirst[numWin[IW-1:0]] <= (winLeft == nwinCur);
                            dir[winBase[10:0]] <= 1'b1;
                            numWin <= numWin + 1'b1;
                        end
                        else
                            bad <= 1'b1;
                        winBase <= winBase + {8'h00, lenCur} + 24'h3;
                        winLeft <= winLeft - 16'h0001;
                    end
                ST_ERASE:
                begin
                    ctx[ptr[IW-1:0]] <= 16'h0000;
                    ptr <= ptr + 11'h001;
                    if (ptr == MAXW - 1)
                    begin
                        searchingLed <= 1'b0;
                        notFoundLed <= bad;
                        if (bad)
                            numWin <= {(IW+1){1'b0}};
                        state <= ST_RUN;
                    end
                end
                default:
                    state <= ST_RUN;
            endcase
        end
    end

endmodule // rcs_record_store

// ===== verilog/rcs_regs.vh
// Register numbers, field positions and timing counts of the record store.
`ifndef RCS_REGS_VH
`define RCS_REGS_VH

// ----------------------------------------------------------------------
// Register indices (register number minus one), register count and front-only register number
// ----------------------------------------------------------------------
`define RCS_IDX_FILE_COUNT 11'h000
`define RCS_IDX_READY 11'h006
`define RCS_IDX_CFG_EXEMPT 11'h007
`define RCS_IDX_FIRST_DEF 12'h002
`define RCS_NUM_IFREGS 12'h800
`define RCS_NUM_FRONT_ONLY 14'h2000

// ----------------------------------------------------------------------
// Field positions and values
// ----------------------------------------------------------------------
`define RCS_BIT_CFG 15
`define RCS_BIT_LOCK 0
`define RCS_BIT_WPROT 1
`define RCS_CMD_WPROT_MASK 16'h01c7
`define RCS_ST_REFUSED 16'h8000
`define RCS_ST_TIMEOUT 16'h4000
`define RCS_MAX_SLOTS 32'd523115

// ----------------------------------------------------------------------
// Timing: worst search is max record number / rate seconds
// ----------------------------------------------------------------------
`define RCS_SEARCH_RATE 40000
`define RCS_CLK_PERIOD_NS 5
`define RCS_SEARCH_CYC_PER_REC (1000000000 / (`RCS_SEARCH_RATE * `RCS_CLK_PERIOD_NS))

`endif
